// ==== src/gpio_pin_block.sv ====
// Twelve-pin general purpose port with Wishbone registers, edge interrupts and wake
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
// Behaviour
// - Each pin configured separately; all pins tristate after reset.
// - Output pins driven push-pull or open-drain per pin setting.
// - Per pin pull-up, pull-down or no pull resistor enabled.
// - Per pin drive strength, one of four settings, applied to driver.
// - Optional per pin glitch filter removes short pulses before edges.
// - Input edge interrupt on rising, falling or both edges per pin.
// - Enabled edge interrupt wakes the block from low-power mode.
// - Pin configuration kept unchanged through low-power mode and wake.
// - All twelve signal pins usable as general purpose when not main function.
// - After reset debug data pin has debug function with pull-up.
// - After reset debug clock pin has debug clock function with pull-down.
// - Debug pins can be reassigned to general purpose use.
// - Trace output on user pins 0-2 off after reset until enabled.
// - Reset pin active low with internal pull-up.
module gpio_pin_block (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gpio_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [gpio_pkg::DAT_W-1:0] wb_dat_i,
  output logic [gpio_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic [gpio_pkg::NPINS-1:0] pin_i,
  output logic [gpio_pkg::NPINS-1:0] pin_o,
  output logic [gpio_pkg::NPINS-1:0] pin_oe_n_o,
  output logic [gpio_pkg::NPINS-1:0] pull_up_o,
  output logic [gpio_pkg::NPINS-1:0] pull_dn_o,
  output logic [2*gpio_pkg::NPINS-1:0] drive_o,
  // Debug and trace functions
  input wire logic dbg_data_out_i,
  input wire logic dbg_data_oe_i,
  output logic dbg_data_in_o,
  output logic dbg_clock_o,
  input wire logic trace_i,
  // Reset pin
  input wire logic rst_pin_n_i,
  output logic rst_pull_up_o,
  output logic reset_req_o,
  // Events
  output logic irq_o,
  output logic wake_o
);
  import gpio_pkg::*;

  function automatic logic [DAT_W-1:0] merge_sel(input logic [DAT_W-1:0] old_v,
                                                 input logic [DAT_W-1:0] new_v,
                                                 input logic [3:0] sel);
    logic [DAT_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  pin_in_if pin_in ();

  pin_input_cond u_cond (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (pin_in)
  );

  pin_cfg_t [NPINS-1:0] cfg_q, cfg_d;
  logic [NPINS-1:0] out_q, out_d, stat_q, stat_d, mask_q, mask_d, set, clr, rise_en;
  logic lp_q, lp_d, wake_q, wake_d, irq_q, irq_d, ack_q, ack_d;
  logic [DAT_W-1:0] rdat_q, rdat_d, wmerge, rsel;
  logic [NPINS-1:0] po_q, po_d, oen_q, oen_d, pu_q, pu_d, pd_q, pd_d;
  logic [2*NPINS-1:0] drv_q, drv_d;
  logic dbg_in_q, dbg_in_d, dbg_clk_q, dbg_clk_d;
  logic rsy1_q, rsy2_q, rreq_q;
  logic req, wr;
  logic [3:0] idx;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !ack_q;
    // Write commits on the edge where the master samples ack
    wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    idx = wb_adr_i[5:2];
    rsel = '0;
    if (wb_adr_i <= OFS_CFG_LAST && wb_adr_i[1:0] == 2'h0) begin
      rsel = {{(DAT_W-CFG_W){1'b0}}, cfg_q[idx]};
    end else begin
      case (wb_adr_i)
        OFS_OUT: rsel = {{(DAT_W-NPINS){1'b0}}, out_q};
        OFS_IN: rsel = {{(DAT_W-NPINS){1'b0}}, pin_in.level};
        OFS_STAT: rsel = {{(DAT_W-NPINS){1'b0}}, stat_q};
        OFS_MASK: rsel = {{(DAT_W-NPINS){1'b0}}, mask_q};
        OFS_LP: rsel = {{(DAT_W-1){1'b0}}, lp_q};
        default: rsel = '0;
      endcase
    end
    wmerge = merge_sel(rsel, wb_dat_i, wb_sel_i);
  end

  // ------------------------------------------------------------------
  // Registers and events
  // ------------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    out_d = out_q;
    mask_d = mask_q;
    clr = '0;
    lp_d = lp_q;
    ack_d = req;
    rdat_d = rdat_q;
    if (req && !wb_we_i) begin
      rdat_d = rsel;
    end
    // Only a bus write alters configuration, in any power mode
    if (wr && wb_adr_i <= OFS_CFG_LAST && wb_adr_i[1:0] == 2'h0) begin
      cfg_d[idx] = pin_cfg_t'(wmerge[CFG_W-1:0]);
    end
    if (wr && wb_adr_i == OFS_OUT) begin
      out_d = wmerge[NPINS-1:0];
    end
    if (wr && wb_adr_i == OFS_MASK) begin
      mask_d = wmerge[NPINS-1:0];
    end
    if (wr && wb_adr_i == OFS_STAT) begin
      clr = wmerge[NPINS-1:0];
    end
    if (wr && wb_adr_i == OFS_LP) begin
      lp_d = wmerge[LP_BIT];
    end
    for (int i = 0; i < NPINS; i++) begin
      set[i] = (pin_in.rise[i] && cfg_q[i].edge_sel[EDGE_RISE_BIT]) ||
               (pin_in.fall[i] && cfg_q[i].edge_sel[EDGE_FALL_BIT]);
      pin_in.filt_en[i] = cfg_q[i].filt_en;
      rise_en[i] = cfg_q[i].edge_sel[EDGE_RISE_BIT];
    end
    stat_d = (stat_q & ~clr) | set;
    wake_d = lp_q && (|set);
    if (wake_d) begin
      lp_d = 1'b0;
    end
    irq_d = |(stat_d & mask_d);
  end

  assign pin_in.raw = pin_i;

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      po_d[i] = 1'b0;
      oen_d[i] = 1'b1;
      case (cfg_q[i].func)
        FUNC_GPIO: begin
          case (cfg_q[i].mode)
            MODE_PUSH: begin
              oen_d[i] = 1'b0;
              po_d[i] = out_q[i];
            end
            MODE_OPEN: begin
              oen_d[i] = out_q[i];
            end
            default: oen_d[i] = 1'b1;
          endcase
        end
        FUNC_MAIN: begin
          if (i == DATA_PIN) begin
            oen_d[i] = ~dbg_data_oe_i;
            po_d[i] = dbg_data_out_i;
          end
        end
        FUNC_TRACE: begin
          if (i < TRACE_PINS) begin
            oen_d[i] = 1'b0;
            po_d[i] = trace_i;
          end
        end
        default: oen_d[i] = 1'b1;
      endcase
      pu_d[i] = cfg_q[i].pull == PULL_UP;
      pd_d[i] = cfg_q[i].pull == PULL_DN;
      drv_d[2*i +: 2] = cfg_q[i].drive;
    end
    dbg_in_d = pin_in.level[DATA_PIN];
    dbg_clk_d = pin_in.level[CLOCK_PIN];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NPINS; i++) begin
        cfg_q[i] <= CFG_RST;
      end
      cfg_q[DATA_PIN] <= CFG_RST_DATA;
      cfg_q[CLOCK_PIN] <= CFG_RST_CLOCK;
      out_q <= '0;
      stat_q <= '0;
      mask_q <= '0;
      lp_q <= 1'b0;
      wake_q <= 1'b0;
      irq_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      po_q <= '0;
      oen_q <= '1;
      pu_q <= '0;
      pu_q[DATA_PIN] <= 1'b1;
      pd_q <= '0;
      pd_q[CLOCK_PIN] <= 1'b1;
      drv_q <= '0;
      dbg_in_q <= 1'b0;
      dbg_clk_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      out_q <= out_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      lp_q <= lp_d;
      wake_q <= wake_d;
      irq_q <= irq_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      po_q <= po_d;
      oen_q <= oen_d;
      pu_q <= pu_d;
      pd_q <= pd_d;
      drv_q <= drv_d;
      dbg_in_q <= dbg_in_d;
      dbg_clk_q <= dbg_clk_d;
    end
  end

  // ------------------------------------------------------------------
  // Reset pin
  // ------------------------------------------------------------------
  // Pin reads released before the first sample, matching a floating pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsy1_q <= 1'b1;
      rsy2_q <= 1'b1;
      rreq_q <= 1'b0;
    end else begin
      rsy1_q <= rst_pin_n_i;
      rsy2_q <= rsy1_q;
      rreq_q <= ~rsy2_q;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign pin_o = po_q;
  assign pin_oe_n_o = oen_q;
  assign pull_up_o = pu_q;
  assign pull_dn_o = pd_q;
  assign drive_o = drv_q;
  assign dbg_data_in_o = dbg_in_q;
  assign dbg_clock_o = dbg_clk_q;
  assign rst_pull_up_o = 1'b1;
  assign reset_req_o = rreq_q;
  assign irq_o = irq_q;
  assign wake_o = wake_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_RESET_TRISTATE: assert property (@(posedge clk_i)
    ($past(rst_i) && !rst_i) |-> (&pin_oe_n_o) && cfg_q[0].func == FUNC_GPIO)
    else $error("Pins not tristate right after reset");
  AST_OPEN_DRAIN_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(cfg_q[0].func) == FUNC_GPIO && $past(cfg_q[0].mode) == MODE_OPEN) |->
      (pin_oe_n_o[0] == $past(out_q[0]) && !pin_o[0]))
    else $error("Open-drain pin drove high or ignored its data");
  AST_PULL_EXCLUSIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    ((pull_up_o & pull_dn_o) == '0) && (pull_up_o[3] == ($past(cfg_q[3].pull) == PULL_UP)))
    else $error("Pull resistors wrong or both enabled");
  AST_DRIVE_APPLIED: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(cfg_q[5].drive) |=> drive_o[11:10] == $past(cfg_q[5].drive))
    else $error("Drive strength not applied to the pin");
  AST_EDGE_SETS_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(pin_in.rise & rise_en)) |=>
      ((stat_q & $past(pin_in.rise & rise_en)) == $past(pin_in.rise & rise_en)))
    else $error("Rising edge did not set its pending flag");
  AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    (lp_q && (|set)) |=> (wake_o && !lp_q))
    else $error("Enabled edge did not wake from low power");
  AST_CFG_HELD: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && $changed(cfg_q)) |-> $past(wr))
    else $error("Configuration changed without a bus write");
  AST_DEBUG_RESET: assert property (@(posedge clk_i)
    $past(rst_i, 2) && !$past(rst_i) |->
      (pull_up_o[DATA_PIN] && pull_dn_o[CLOCK_PIN] && cfg_q[CLOCK_PIN].func == FUNC_MAIN))
    else $error("Debug pins not in debug function after reset");
  AST_TRACE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_q[1].func != FUNC_TRACE && $past(cfg_q[1].func) != FUNC_TRACE &&
     $past(cfg_q[1].mode) == MODE_TRI) |-> pin_oe_n_o[1])
    else $error("Trace drove a pin while disabled");
  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> ((stat_q & $past(stat_q & ~clr)) == $past(stat_q & ~clr)) &&
      (irq_o == |(stat_q & mask_q)))
    else $error("Pending flag lost or interrupt wrong");
  AST_RESET_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
    (!rst_pin_n_i ##1 !rst_pin_n_i ##1 !rst_pin_n_i) |=> reset_req_o)
    else $error("Low reset pin not reported");

  COV_WAKE: cover property (@(posedge clk_i) disable iff (rst_i) $rose(wake_o));
  COV_IRQ: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  COV_DEBUG_TO_GPIO: cover property (@(posedge clk_i) disable iff (rst_i)
    $past(cfg_q[DATA_PIN].func) == FUNC_MAIN && cfg_q[DATA_PIN].func == FUNC_GPIO);
endmodule

// ==== src/gpio_pkg.sv ====
// Shared constants, register map and configuration layout of the pin block
package gpio_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NPINS = 12;
  localparam int DATA_PIN = 10;
  localparam int CLOCK_PIN = 11;
  localparam int TRACE_PINS = 3;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CFG_BASE = 8'h00;
  localparam logic [7:0] OFS_CFG_LAST = 8'h2C;
  localparam logic [7:0] OFS_OUT = 8'h40;
  localparam logic [7:0] OFS_IN = 8'h44;
  localparam logic [7:0] OFS_STAT = 8'h48;
  localparam logic [7:0] OFS_MASK = 8'h4C;
  localparam logic [7:0] OFS_LP = 8'h50;
  localparam int LP_BIT = 0;

  // ------------------------------------------------------------------
  // Per-pin configuration word
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_TRI = 2'h0;
  localparam logic [1:0] MODE_PUSH = 2'h1;
  localparam logic [1:0] MODE_OPEN = 2'h2;
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DN = 2'h2;
  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic [1:0] FUNC_MAIN = 2'h1;
  localparam logic [1:0] FUNC_TRACE = 2'h2;
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  localparam int CFG_W = 11;

  typedef struct packed {
    logic [1:0] func;
    logic [1:0] edge_sel;
    logic filt_en;
    logic [1:0] drive;
    logic [1:0] pull;
    logic [1:0] mode;
  } pin_cfg_t;

  localparam pin_cfg_t CFG_RST = '0;
  localparam pin_cfg_t CFG_RST_DATA = '{func: FUNC_MAIN, pull: PULL_UP, default: '0};
  localparam pin_cfg_t CFG_RST_CLOCK = '{func: FUNC_MAIN, pull: PULL_DN, default: '0};

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int FILT_TIME_NS = 300;
  localparam int FILT_CYCLES = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] FILT_LAST = 2'(FILT_CYCLES - 1);

endpackage

// ==== src/pin_in_if.sv ====
// Input conditioning signals passed between the pin core and its input stage
`timescale 1ns/1ps
interface pin_in_if;
  logic [gpio_pkg::NPINS-1:0] raw;
  logic [gpio_pkg::NPINS-1:0] filt_en;
  logic [gpio_pkg::NPINS-1:0] level;
  logic [gpio_pkg::NPINS-1:0] rise;
  logic [gpio_pkg::NPINS-1:0] fall;
  modport cond (input raw, input filt_en, output level, output rise, output fall);
  modport core (output raw, output filt_en, input level, input rise, input fall);
endinterface

// ==== src/pin_input_cond.sv ====
// Input stage: two-stage synchroniser, glitch filter and edge detection
`timescale 1ns/1ps
module pin_input_cond (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Conditioned levels and edges
  pin_in_if.cond bus
);
  import gpio_pkg::*;

  logic [NPINS-1:0] s1_q, s1_d, s2_q, s2_d;
  logic [NPINS-1:0] filt_q, filt_d, prev_q, prev_d, cond;
  logic [1:0] cnt_q [NPINS];
  logic [1:0] cnt_d [NPINS];

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s1_d = bus.raw;
    s2_d = s1_q;
    for (int i = 0; i < NPINS; i++) begin
      filt_d[i] = filt_q[i];
      cnt_d[i] = 2'h0;
      if (s2_q[i] != filt_q[i]) begin
        // Level must differ on consecutive cycles before it is accepted
        if (cnt_q[i] == FILT_LAST) begin
          filt_d[i] = s2_q[i];
        end else begin
          cnt_d[i] = cnt_q[i] + 2'h1;
        end
      end
      cond[i] = bus.filt_en[i] ? filt_q[i] : s2_q[i];
    end
    prev_d = cond;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      filt_q <= '0;
      prev_q <= '0;
      for (int i = 0; i < NPINS; i++) begin
        cnt_q[i] <= 2'h0;
      end
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      filt_q <= filt_d;
      prev_q <= prev_d;
      for (int i = 0; i < NPINS; i++) begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  // Toggling a filter enable may itself show as one edge
  assign bus.level = cond;
  assign bus.rise = cond & ~prev_q;
  assign bus.fall = ~cond & prev_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_SYNC_TWO_STAGE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i, 1) && !$past(rst_i, 2) && bus.filt_en == '0) |->
      bus.level == $past(bus.raw, 2))
    else $error("Unfiltered level is not the raw input two cycles late");
  AST_FILTER_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && $changed(filt_q[0])) |->
      ($past(s2_q[0], 1) == filt_q[0] && $past(s2_q[0], 2) == filt_q[0] &&
       $past(s2_q[0], 3) == filt_q[0]))
    else $error("Filter accepted a pulse shorter than the filter time");
  COV_FILTER_ACCEPT: cover property (@(posedge clk_i) disable iff (rst_i)
    bus.filt_en[0] && $rose(filt_q[0]));
endmodule

// ==== verification/ext_pins.sv ====
// Model of the external logic and wiring seen at the twelve pins
`timescale 1ns/1ps
module ext_pins (
  // Clock
  input wire logic clk_i,
  // External drivers
  input wire logic [gpio_pkg::NPINS-1:0] drv_en_i,
  input wire logic [gpio_pkg::NPINS-1:0] drv_val_i,
  // Device side of each pin
  input wire logic [gpio_pkg::NPINS-1:0] pin_o_i,
  input wire logic [gpio_pkg::NPINS-1:0] oe_n_i,
  input wire logic [gpio_pkg::NPINS-1:0] pu_i,
  input wire logic [gpio_pkg::NPINS-1:0] pd_i,
  // Resolved wire level
  output logic [gpio_pkg::NPINS-1:0] level_o
);
  import gpio_pkg::*;
  logic [NPINS-1:0] last_q = '0;
  always_ff @(posedge clk_i) begin
    last_q <= level_o;
  end
  // Floating wire toggles, so a stale level is never mistaken for a driven one
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (!oe_n_i[i]) begin
        level_o[i] = pin_o_i[i];
      end else if (drv_en_i[i]) begin
        level_o[i] = drv_val_i[i];
      end else if (pu_i[i]) begin
        level_o[i] = 1'b1;
      end else if (pd_i[i]) begin
        level_o[i] = 1'b0;
      end else begin
        level_o[i] = ~last_q[i];
      end
    end
  end
endmodule

// ==== verification/gpio_pin_block_tb.sv ====
// Self-checking bench for the twelve-pin port
`timescale 1ns/1ps
module gpio_pin_block_tb;
  import gpio_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic wb_we_i = 0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [DAT_W-1:0] wb_dat_i = '0;
  logic [DAT_W-1:0] wb_dat_o;
  logic [DAT_W-1:0] rd;
  logic wb_ack_o;
  logic [NPINS-1:0] pin_i, pin_o, pin_oe_n_o, pull_up_o, pull_dn_o;
  logic [NPINS-1:0] drv_en = '0;
  logic [NPINS-1:0] drv_val = '0;
  logic [2*NPINS-1:0] drive_o;
  logic dbg_data_out_i = 0;
  logic dbg_data_oe_i = 0;
  logic trace_i = 1;
  logic rst_pin_n_i = 1;
  logic dbg_data_in_o, dbg_clock_o, rst_pull_up_o, reset_req_o, irq_o, wake_o;
  int fails = 0;
  int n_compared = 0;
  logic [10:0] cfg [NPINS];

  always #50 clk_i = ~clk_i;

  gpio_pin_block uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_i, .pin_o, .pin_oe_n_o,
    .pull_up_o, .pull_dn_o, .drive_o, .dbg_data_out_i, .dbg_data_oe_i, .dbg_data_in_o,
    .dbg_clock_o, .trace_i, .rst_pin_n_i, .rst_pull_up_o, .reset_req_o, .irq_o, .wake_o);

  ext_pins far (.clk_i(clk_i), .drv_en_i(drv_en), .drv_val_i(drv_val), .pin_o_i(pin_o),
    .oe_n_i(pin_oe_n_o), .pu_i(pull_up_o), .pd_i(pull_dn_o), .level_o(pin_i));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Classic single cycle; no latency assumed, bounded wait for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      results();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask

  task automatic pin(input int k, input logic v);
    @(posedge clk_i);
    drv_val[k] <= v;
  endtask

  function automatic logic oe_exp(input logic [10:0] c, input logic o);
    return c[1:0] == MODE_PUSH ? 1'b0 : c[1:0] == MODE_OPEN ? o : 1'b1;
  endfunction

  function automatic logic [10:0] cfg_rst(input int i);
    return i == DATA_PIN ? CFG_RST_DATA : i == CLOCK_PIN ? CFG_RST_CLOCK : CFG_RST;
  endfunction

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int k;
    int e;
    logic [11:0] v;
    logic [11:0] o;
    logic [10:0] c;
    void'($urandom(32'hfb03_8876));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    drv_en[CLOCK_PIN] <= 1;
    drv_val[CLOCK_PIN] <= 1;
    #1;
    chk("oe_n", pin_oe_n_o, 32'h0000_0fff);
    chk("pull_up", pull_up_o, 32'h0000_0400);
    chk("pull_dn", pull_dn_o, 32'h0000_0800);
    chk("rst_pull", rst_pull_up_o, 1);
    chk("irq", irq_o, 0);
    settle(5);
    chk("dbg_in", dbg_data_in_o, 1);
    chk("dbg_clk", dbg_clock_o, 1);
    for (int i = 0; i < NPINS; i++) begin
      wb(0, 8'(4 * i), 0);
      chk("cfg_rst", rd, {21'h0, cfg_rst(i)});
    end
    wb(0, 8'h60, 0);
    chk("unmapped", rd, 0);
    dbg_data_oe_i <= 1;
    dbg_data_out_i <= 1;
    settle(3);
    chk("dbg_oe", pin_oe_n_o[DATA_PIN], 0);
    chk("dbg_o", pin_o[DATA_PIN], 1);
    // Random per-pin output setup, debug pins taken over as plain pins
    o = 12'($urandom);
    wb(1, OFS_OUT, {20'h0, o});
    for (int i = 0; i < NPINS; i++) begin
      cfg[i] = 11'($urandom) & 11'h03f;
      if (cfg[i][3:2] == 2'h3) cfg[i][3:2] = PULL_NONE;
      if (i == 0) cfg[i][1:0] = MODE_OPEN;
      wb(1, 8'(4 * i), {21'h0, cfg[i]});
    end
    settle(2);
    for (int i = 0; i < NPINS; i++) begin
      chk("oe_n", pin_oe_n_o[i], oe_exp(cfg[i], o[i]));
      if (cfg[i][1:0] == MODE_PUSH) chk("out", pin_o[i], o[i]);
      chk("pu", pull_up_o[i], cfg[i][3:2] == PULL_UP);
      chk("pd", pull_dn_o[i], cfg[i][3:2] == PULL_DN);
      chk("drive", drive_o[2*i+:2], cfg[i][5:4]);
    end
    // Inputs: all tristate, far side drives a random pattern
    for (int i = 0; i < NPINS; i++) wb(1, 8'(4 * i), 0);
    v = 12'($urandom);
    @(posedge clk_i);
    drv_en <= 12'hfff;
    drv_val <= v;
    settle(4);
    wb(0, OFS_IN, 0);
    chk("in", rd, {20'h0, v});
    // Edge selection, sticky status, mask and clear
    k = $urandom_range(9, 0);
    for (e = 1; e < 4; e++) begin
      pin(k, 0);
      wb(1, 8'(4 * k), 32'(e) << 7);
      wb(1, OFS_MASK, 32'h1 << k);
      settle(6);
      wb(1, OFS_STAT, 32'h0000_0fff);
      pin(k, 1);
      settle(6);
      wb(0, OFS_STAT, 0);
      chk("stat_rise", rd, e[0] ? 32'h1 << k : 0);
      chk("irq_rise", irq_o, e[0]);
      pin(k, 0);
      settle(6);
      wb(0, OFS_STAT, 0);
      chk("stat_fall", rd, 32'h1 << k);
      wb(1, OFS_MASK, 0);
      settle(2);
      chk("irq_masked", irq_o, 0);
      wb(1, OFS_STAT, 32'h1 << k);
      wb(0, OFS_STAT, 0);
      chk("stat_clr", rd, 0);
    end
    // Glitch filter: short pulse dropped, long level accepted
    wb(1, 8'(4 * k), 32'h0000_00c0);
    settle(6);
    wb(1, OFS_STAT, 32'h0000_0fff);
    pin(k, 1);
    pin(k, 0);
    settle(8);
    wb(0, OFS_STAT, 0);
    chk("filt_short", rd, 0);
    pin(k, 1);
    settle(8);
    wb(0, OFS_STAT, 0);
    chk("filt_long", rd, 32'h1 << k);
    // Wake from low power, configuration kept
    c = (11'($urandom) & 11'h03c) | 11'h080;
    pin(k, 0);
    wb(1, 8'(4 * k), {21'h0, c});
    settle(6);
    wb(1, OFS_STAT, 32'h0000_0fff);
    wb(1, OFS_LP, 32'h1);
    pin(k, 1);
    e = 0;
    for (int t = 0; t < 20 && e == 0; t++) begin
      settle(1);
      if (wake_o === 1'b1) e = 1;
    end
    chk("wake", e, 1);
    wb(0, OFS_LP, 0);
    chk("lp_clr", rd, 0);
    wb(0, 8'(4 * k), 0);
    chk("cfg_kept", rd, {21'h0, c});
    chk("pull_kept", pull_up_o[k], c[3:2] == PULL_UP);
    // Trace output on pin 0 once enabled, following trace_i
    wb(1, 8'h00, {21'h0, FUNC_TRACE, 7'h0, MODE_PUSH});
    settle(3);
    chk("trace_oe", pin_oe_n_o[0], 0);
    chk("trace_hi", pin_o[0], 1);
    @(posedge clk_i);
    trace_i <= 0;
    settle(3);
    chk("trace_lo", pin_o[0], 0);
    // Reset pin
    @(posedge clk_i);
    rst_pin_n_i <= 0;
    settle(4);
    chk("rst_req", reset_req_o, 1);
    @(posedge clk_i);
    rst_pin_n_i <= 1;
    settle(5);
    chk("rst_rel", reset_req_o, 0);
    results();
  end
endmodule
